// *** verilog/usart_quirks_map.svh ***
// Constants for the serial unit: reset values, field positions and timing counts.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef USART_QUIRKS_MAP_SVH
`define USART_QUIRKS_MAP_SVH

// ***********************************
// Reset values
// ***********************************
`define RTS_RESET_VAL 1'b0
`define OVR_ERR_RESET_VAL 1'b0
`define TAINT_RESET_VAL 1'b0

// ***********************************
// Pin vector positions
// ***********************************
`define PIN_SCK 0
`define PIN_MOSI 1
`define PIN_CS_N 2
`define PIN_EXT_CLK 3
`define PIN_COUNT 4
// Idle pin levels: deselected chip select high, clocks and data low
`define PIN_RESET_VAL 4'h4

// ***********************************
// Timing counts
// ***********************************
// External clock period must be at least this many internal clocks
`define MIN_EXT_CLK_RATIO 4'h9
`define RATIO_CNT_MAX 4'hf
`define BIT_CNT_MAX 4'hf
`define CHAR_LEN_DEFAULT 4'h8

`endif

// *** verilog/usart_quirks_pkg.sv ***
// Types shared by the serial unit's design files.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
package usart_quirks_pkg;

  // Operating mode of the unit
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_HW_HANDSHAKE,
    MODE_SPI_SLAVE,
    MODE_ISO_T1,
    MODE_SYNC_SLAVE
  } mode_e;

  // Receiver recovery state in smart-card block mode
  typedef enum logic [1:0] {
    ISO_RX_READY,
    ISO_RX_STUCK,
    ISO_RX_RESET,
    ISO_RX_MODE_OK
  } iso_state_e;

  // Raw SPI slave pins
  typedef struct packed {
    logic cs_n;
    logic mosi;
    logic sck;
  } spi_pins_s;

  // One received SPI character
  typedef struct packed {
    logic [8:0] data;
    logic valid;
    logic suspect;
  } rx_word_s;

endpackage

// *** verilog/pin_sync.sv ***
// Three-stage synchroniser for a group of asynchronous input pins.
// Assumes one clock; the output updates only when stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] stable
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_next;

  // Bits whose last two stages agree are taken; others hold
  assign stable_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & stable);

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      // Reset to idle levels so no false edge follows reset
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      stable <= RST_VAL;
    end
    else if (ce)
    begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable <= stable_next;
    end
  end

endmodule

`default_nettype wire

// *** verilog/usart_quirks.sv ***
// Serial unit control: request-to-send handling, SPI slave over-length check,
// smart-card block-mode receive recovery, error counter, external clock check.
// Assumes one clock, software pulses on command inputs, asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
`include "usart_quirks_map.svh"

module usart_quirks #(
  parameter int DATA_W = 9,
  parameter int CNT_W = 8,
  parameter bit AFFECTED_REV = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire usart_quirks_pkg::mode_e mode,
  input wire logic [3:0] char_len,
  input wire logic rts_force_high_cmd,
  input wire logic rts_drive_low_cmd,
  input wire logic dma_rx_full,
  input wire logic dma_rx_fresh,
  input wire logic soft_rst,
  input wire logic rx_soft_rst,
  input wire logic mode_reg_wr,
  input wire logic command_reg_wr,
  input wire logic tx_done,
  input wire logic iso_rx_byte,
  input wire logic iso_err_evt,
  input wire usart_quirks_pkg::spi_pins_s spi_pins,
  input wire logic ext_clk,
  input wire logic ovr_err_clr,
  output logic rts,
  output usart_quirks_pkg::rx_word_s rx_word,
  output logic spi_ovr_err,
  output logic [CNT_W-1:0] iso_error_count_reg,
  output logic iso_rx_ok,
  output logic iso_rx_blocked,
  output logic ext_clk_fast_err
);

  // ***********************************
  // Pin synchronisation
  // ***********************************
  logic [`PIN_COUNT-1:0] pins_raw;
  logic [`PIN_COUNT-1:0] pins_stable;

  assign pins_raw = {ext_clk, spi_pins.cs_n, spi_pins.mosi, spi_pins.sck};

  pin_sync #(.W(`PIN_COUNT), .RST_VAL(`PIN_RESET_VAL)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .pins(pins_raw),
    .stable(pins_stable)
  );

  logic [`PIN_COUNT-1:0] pins_prev_reg;
  wire sck_rise = pins_stable[`PIN_SCK] & ~pins_prev_reg[`PIN_SCK];
  wire cs_fall = ~pins_stable[`PIN_CS_N] & pins_prev_reg[`PIN_CS_N];
  wire cs_rise = pins_stable[`PIN_CS_N] & ~pins_prev_reg[`PIN_CS_N];
  wire cs_active = ~pins_stable[`PIN_CS_N];
  wire ext_rise = pins_stable[`PIN_EXT_CLK] & ~pins_prev_reg[`PIN_EXT_CLK];
  wire mosi_bit = pins_stable[`PIN_MOSI];

  // Previous settled pin levels for edge detection
  always_ff @(posedge clk)
  begin
    if (!rstn)
      pins_prev_reg <= `PIN_RESET_VAL;
    else if (ce)
      pins_prev_reg <= pins_stable;
  end

  // ***********************************
  // Request-to-send
  // ***********************************
  wire in_handshake = (mode == usart_quirks_pkg::MODE_HW_HANDSHAKE);
  logic rts_next;

  // Commands beat the automatic handshake; force-high beats drive-low
  // force high command
  assign rts_next = rts_force_high_cmd ? 1'b1 :
                    rts_drive_low_cmd ? 1'b0 :
                    (in_handshake && dma_rx_full) ? 1'b1 :
                    (in_handshake && dma_rx_fresh) ? 1'b0 : rts;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      rts <= `RTS_RESET_VAL;
    else if (ce)
      rts <= rts_next;
  end

  // ***********************************
  // SPI slave receiver
  // ***********************************
  wire in_spi = (mode == usart_quirks_pkg::MODE_SPI_SLAVE);
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [DATA_W-1:0] shift_reg;
  logic [DATA_W-1:0] shift_next;
  logic taint_reg;
  logic taint_next;
  logic frame_taint_reg;
  logic frame_taint_next;
  logic ovr_err_next;
  usart_quirks_pkg::rx_word_s rx_word_next;

  // Frame end with more bits than configured
  wire frame_end = in_spi && cs_rise;
  wire frame_over = frame_end && (bit_cnt_reg > char_len);
  wire frame_good = frame_end && (bit_cnt_reg == char_len);

  // Saturating bit counter; cleared at frame start or soft reset
  assign bit_cnt_next = (soft_rst || cs_fall) ? 4'h0 :
                        (in_spi && cs_active && sck_rise && bit_cnt_reg != `BIT_CNT_MAX) ?
                        bit_cnt_reg + 4'h1 : bit_cnt_reg;

  // stale bits kept after error
  // A tainted frame starts on top of the previous contents instead of zero
  assign shift_next = ((soft_rst || cs_fall) && !taint_reg) ? '0 :
                      (in_spi && cs_active && sck_rise) ? {shift_reg[DATA_W-2:0], mosi_bit} :
                      shift_reg;

  // taint survives soft reset
  // Only a full reset or the end of the frame after the error clears it; that frame carries it away
  assign taint_next = (frame_over && AFFECTED_REV) ? 1'b1 :
                      (frame_end && frame_taint_reg) ? 1'b0 : taint_reg;
  assign frame_taint_next = cs_fall ? taint_reg : frame_taint_reg;

  // over-length error flag
  // Set wins over a clear in the same cycle
  assign ovr_err_next = frame_over ? 1'b1 :
                        (ovr_err_clr || soft_rst) ? 1'b0 : spi_ovr_err;

  // Deliver a character only when exactly the configured length arrived
  always_comb
  begin
    rx_word_next = rx_word;
    rx_word_next.valid = frame_good;
    if (frame_good)
    begin
      rx_word_next.data = shift_reg;
      rx_word_next.suspect = frame_taint_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= '0;
      taint_reg <= `TAINT_RESET_VAL;
      frame_taint_reg <= `TAINT_RESET_VAL;
      spi_ovr_err <= `OVR_ERR_RESET_VAL;
      rx_word <= '0;
    end
    else if (ce)
    begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      taint_reg <= taint_next;
      frame_taint_reg <= frame_taint_next;
      spi_ovr_err <= ovr_err_next;
      rx_word <= rx_word_next;
    end
  end

  // ***********************************
  // Smart-card block mode receive recovery
  // ***********************************
  wire in_iso = (mode == usart_quirks_pkg::MODE_ISO_T1);
  usart_quirks_pkg::iso_state_e iso_state_reg;
  usart_quirks_pkg::iso_state_e iso_state_next;

  // receiver stuck after transmit
  // Recovery needs receiver reset, then mode write, then command write
  always_comb
  begin
    iso_state_next = iso_state_reg;
    case (iso_state_reg)
      usart_quirks_pkg::ISO_RX_READY:
        if (in_iso && tx_done)
          iso_state_next = usart_quirks_pkg::ISO_RX_STUCK;
      usart_quirks_pkg::ISO_RX_STUCK:
        if (rx_soft_rst)
          iso_state_next = usart_quirks_pkg::ISO_RX_RESET;
      usart_quirks_pkg::ISO_RX_RESET:
        if (mode_reg_wr)
          iso_state_next = usart_quirks_pkg::ISO_RX_MODE_OK;
      usart_quirks_pkg::ISO_RX_MODE_OK:
        if (command_reg_wr)
          iso_state_next = usart_quirks_pkg::ISO_RX_READY;
      default:
        iso_state_next = usart_quirks_pkg::ISO_RX_STUCK;
    endcase
  end

  wire iso_ready = (iso_state_reg == usart_quirks_pkg::ISO_RX_READY);

  // ***********************************
  // Error count
  // ***********************************
  logic [CNT_W-1:0] err_cnt_next;

  // count reads as zero
  // Fixed parts saturate at all ones; soft reset clears the count
  assign err_cnt_next = (AFFECTED_REV || soft_rst) ? '0 :
                        (in_iso && iso_err_evt && iso_error_count_reg != {CNT_W{1'b1}}) ?
                        iso_error_count_reg + {{(CNT_W-1){1'b0}}, 1'b1} : iso_error_count_reg;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      iso_state_reg <= usart_quirks_pkg::ISO_RX_READY;
      iso_rx_ok <= 1'b0;
      iso_rx_blocked <= 1'b0;
      iso_error_count_reg <= '0;
    end
    else if (ce)
    begin
      iso_state_reg <= iso_state_next;
      iso_rx_ok <= in_iso && iso_rx_byte && iso_ready;
      iso_rx_blocked <= (iso_state_next != usart_quirks_pkg::ISO_RX_READY);
      iso_error_count_reg <= err_cnt_next;
    end
  end

  // ***********************************
  // External clock rate check
  // ***********************************
  wire in_sync_slave = (mode == usart_quirks_pkg::MODE_SYNC_SLAVE);
  logic [3:0] period_cnt_reg;
  logic [3:0] period_cnt_next;
  logic fast_err_next;

  // Cycles since last rising edge, saturating so long gaps never wrap
  assign period_cnt_next = ext_rise ? 4'h1 :
                           (period_cnt_reg != `RATIO_CNT_MAX) ? period_cnt_reg + 4'h1 : period_cnt_reg;

  // peer clock too fast
  // Sticky; a new violation wins over a soft reset clear
  assign fast_err_next = (in_sync_slave && ext_rise && period_cnt_reg < `MIN_EXT_CLK_RATIO) ? 1'b1 :
                         soft_rst ? 1'b0 : ext_clk_fast_err;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      period_cnt_reg <= `RATIO_CNT_MAX;
      ext_clk_fast_err <= 1'b0;
    end
    else if (ce)
    begin
      period_cnt_reg <= period_cnt_next;
      ext_clk_fast_err <= fast_err_next;
    end
  end

endmodule

`default_nettype wire

// *** bench/usart_quirks_sva.sv ***
// Checker on the serial unit's top-level ports.
// Assumes bind onto usart_quirks, parameters handed on.
`timescale 1ns/10ps
`default_nettype none
module usart_quirks_sva #(
  parameter int CNT_W = 8,
  parameter bit AFFECTED_REV = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire usart_quirks_pkg::mode_e mode,
  input wire logic rts_force_high_cmd,
  input wire logic rts_drive_low_cmd,
  input wire logic dma_rx_full,
  input wire logic dma_rx_fresh,
  input wire logic rts,
  input wire usart_quirks_pkg::rx_word_s rx_word,
  input wire logic spi_ovr_err,
  input wire logic [CNT_W-1:0] iso_error_count_reg
);
  // Buffer events only count in handshake mode
  wire logic hs = mode == usart_quirks_pkg::MODE_HW_HANDSHAKE;
  wire logic evt = rts_force_high_cmd | rts_drive_low_cmd | hs & (dma_rx_full | dma_rx_fresh);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ************
  // Assertions
  // ************
  a_force_high: assert property (ce && rts_force_high_cmd |=> rts)
    else $error("rts not high");
  a_drive_low: assert property (ce && rts_drive_low_cmd && !rts_force_high_cmd |=> !rts)
    else $error("rts not low");
  a_full_raises: assert property (ce && hs && dma_rx_full && !rts_drive_low_cmd |=> rts)
    else $error("rts low on full buffer");
  a_fresh_lowers: assert property (ce && hs && dma_rx_fresh && !dma_rx_full && !rts_force_high_cmd |=> !rts)
    else $error("rts high on fresh buffer");
  a_rts_steady: assert property (!(ce && evt) |=> $stable(rts))
    else $error("rts moved without cause");
  a_count_zero: assert property (!AFFECTED_REV || iso_error_count_reg == {CNT_W{1'b0}})
    else $error("error count not zero");
  a_valid_pulse: assert property (ce && rx_word.valid |=> !rx_word.valid)
    else $error("valid longer than one cycle");
  a_ovr_no_word: assert property ($rose(spi_ovr_err) |-> !rx_word.valid)
    else $error("word delivered with overlength");
  a_taint_flag: assert property ($rose(rx_word.suspect) |-> rx_word.valid)
    else $error("suspect without word");
  // Main scenarios reached
  c_rts: cover property ($rose(rts));
  c_ovr: cover property ($rose(spi_ovr_err));
  c_taint: cover property (rx_word.valid && rx_word.suspect);
endmodule
bind usart_quirks usart_quirks_sva #(.CNT_W(CNT_W), .AFFECTED_REV(AFFECTED_REV)) u_usart_quirks_sva (
  .clk, .rstn, .ce, .mode, .rts_force_high_cmd, .rts_drive_low_cmd, .dma_rx_full,
  .dma_rx_fresh, .rts, .rx_word, .spi_ovr_err, .iso_error_count_reg);
`default_nettype wire

// *** bench/spi_master_model.sv ***
// Serial peer: SPI master pins and external serial clock.
// Assumes the unit's clock paces it; drives follow a rising edge.
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
  input wire logic clk,
  output usart_quirks_pkg::spi_pins_s pins,
  output logic ext_clk
);
  // Idle: deselected, serial clock low
  initial
  begin
    pins = 3'b100;
    ext_clk = 1'b0;
  end
  // Frame MSB first; ten clocks a bit keep each level settled
  task automatic frame(input int n, input logic [8:0] d);
    int i;
    @(posedge clk);
    pins.cs_n <= 1'b0;
    for (i = n - 1; i >= 0; i--)
    begin
      repeat (5) @(posedge clk);
      pins.sck <= 1'b0;
      pins.mosi <= d[i];
      repeat (5) @(posedge clk);
      pins.sck <= 1'b1;
    end
    repeat (5) @(posedge clk);
    pins.sck <= 1'b0;
    repeat (5) @(posedge clk);
    pins.cs_n <= 1'b1;
    // Released data line has no pull, so show the inverse
    pins.mosi <= ~pins.mosi;
  endtask
  task automatic ext_tick(input int gap);
    @(posedge clk);
    ext_clk <= 1'b1;
    repeat (gap / 2) @(posedge clk);
    ext_clk <= 1'b0;
    repeat (gap - gap / 2 - 1) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** bench/usart_quirks_bench.sv ***
// Self-checking bench for the serial unit control block.
// Assumes design, checker and peer model compiled before it.
`timescale 1ns/10ps
`default_nettype none
module usart_quirks_bench;
  logic clk;
  logic rstn;
  logic ce;
  logic [3:0] char_len;
  usart_quirks_pkg::mode_e mode;
  logic [11:0] cmd;
  usart_quirks_pkg::spi_pins_s pins;
  logic ext_clk;
  logic rts;
  usart_quirks_pkg::rx_word_s rx_word;
  usart_quirks_pkg::rx_word_s last;
  logic ovr;
  logic [7:0] cnt;
  logic ok;
  logic blk;
  logic fast;
  int num_errors = 0;
  int comparisons = 0;
  int words = 0;
  usart_quirks u_usart_quirks (.clk(clk), .rstn(rstn), .ce(ce), .mode(mode), .char_len(char_len),
    .rts_force_high_cmd(cmd[0]), .rts_drive_low_cmd(cmd[1]), .dma_rx_full(cmd[2]),
    .dma_rx_fresh(cmd[3]), .soft_rst(cmd[4]), .rx_soft_rst(cmd[5]), .mode_reg_wr(cmd[6]),
    .command_reg_wr(cmd[7]), .tx_done(cmd[8]), .iso_rx_byte(cmd[9]), .iso_err_evt(cmd[10]),
    .spi_pins(pins), .ext_clk(ext_clk), .ovr_err_clr(cmd[11]), .rts(rts), .rx_word(rx_word),
    .spi_ovr_err(ovr), .iso_error_count_reg(cnt), .iso_rx_ok(ok), .iso_rx_blocked(blk),
    .ext_clk_fast_err(fast));
  spi_master_model peer (.clk(clk), .pins(pins), .ext_clk(ext_clk));
  // Clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Valid lasts one cycle, so latch each word
  always @(posedge clk)
  begin
    if (rx_word.valid === 1'b1)
    begin
      last <= rx_word;
      words <= words + 1;
    end
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle command pulse, outputs sampled at the next falling edge
  task automatic fire(input logic [11:0] m);
    @(posedge clk);
    cmd <= m;
    @(posedge clk);
    cmd <= 12'h000;
    @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog, well past the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  // ************
  // Test sequence
  // ************
  initial
  begin
    rstn = 1'b0;
    mode = usart_quirks_pkg::MODE_NORMAL;
    cmd = 12'h000;
    ce = 1'b1;
    char_len = 4'h8;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk({rts, ovr, blk, fast, ok}, 9'h000);
    fire(12'h004);
    chk(rts, 1'b0);
    fire(12'h001);
    chk(rts, 1'b1);
    fire(12'h002);
    chk(rts, 1'b0);
    // Clock enable low freezes the command path
    @(posedge clk);
    ce <= 1'b0;
    fire(12'h001);
    chk(rts, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    fire(12'h003);
    chk(rts, 1'b1);
    fire(12'h002);
    @(posedge clk);
    mode <= usart_quirks_pkg::MODE_HW_HANDSHAKE;
    fire(12'h004);
    chk(rts, 1'b1);
    fire(12'h008);
    chk(rts, 1'b0);
    @(posedge clk);
    mode <= usart_quirks_pkg::MODE_SPI_SLAVE;
    peer.frame(8, 9'h0a5);
    repeat (10) @(negedge clk);
    chk({ovr, 8'(words)}, 9'h001);
    chk(last.data, 9'h0a5);
    peer.frame(9, 9'h1c3);
    repeat (10) @(negedge clk);
    chk({ovr, 8'(words)}, 9'h101);
    fire(12'h010);
    chk(ovr, 1'b0);
    peer.frame(8, 9'h03c);
    repeat (10) @(negedge clk);
    chk({last.suspect, last.data[7:0]}, 9'h13c);
    peer.frame(8, 9'h0f0);
    repeat (10) @(negedge clk);
    chk({last.suspect, 8'(words)}, 9'h003);
    chk(last.data, 9'h0f0);
    // Nine-bit characters are legal once configured
    @(posedge clk);
    char_len <= 4'h9;
    peer.frame(9, 9'h1a5);
    repeat (10) @(negedge clk);
    chk({ovr, 8'(words)}, 9'h004);
    chk(last.data, 9'h1a5);
    @(posedge clk);
    char_len <= 4'h8;
    peer.frame(9, 9'h155);
    repeat (10) @(negedge clk);
    fire(12'h800);
    chk(ovr, 1'b0);
    @(posedge clk);
    mode <= usart_quirks_pkg::MODE_ISO_T1;
    fire(12'h100);
    chk(blk, 1'b1);
    fire(12'h200);
    chk(ok, 1'b0);
    fire(12'h040);
    fire(12'h080);
    chk(blk, 1'b1);
    fire(12'h020);
    fire(12'h040);
    fire(12'h080);
    chk(blk, 1'b0);
    fire(12'h200);
    chk(ok, 1'b1);
    fire(12'h400);
    fire(12'h400);
    chk(cnt, 9'h000);
    @(posedge clk);
    mode <= usart_quirks_pkg::MODE_SYNC_SLAVE;
    peer.ext_tick(20);
    peer.ext_tick(20);
    fire(12'h010);
    repeat (3) peer.ext_tick(9);
    repeat (6) @(negedge clk);
    chk(fast, 1'b0);
    repeat (2) peer.ext_tick(8);
    repeat (6) @(negedge clk);
    chk(fast, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
